//--- rvc_pkg.sv
// Package of register map and field constants for the regulator control block
package rvc_pkg;
    localparam logic [7:0] REG_ADDR = 8'hc9;
    localparam int OFF_BIT = 7;
    localparam int PRESENT_BIT = 6;
    localparam int POL_BIT = 5;
    localparam int LOWPWR_BIT = 4;
    localparam logic [3:0] RSVD_RESET = 4'h0;
    localparam logic OFF_RESET = 1'b0;
    localparam logic POL_RESET = 1'b0;
    localparam logic LOWPWR_RESET = 1'b0;
    localparam int SYNC_STAGES = 2;
endpackage : rvc_pkg

//--- rvc_regulator_control.sv
// Regulator and bus-voltage control register on the core's special-register port
`timescale 1ns/1ps
module rvc_regulator_control (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic sfrRead,
    input wire logic [7:0] sfrWdata,
    output logic [7:0] sfrRdata,
    output logic sfrSelected,
    input wire logic busVoltagePin,
    input wire logic busVoltageIrqEnable,
    input wire logic busResetSourceEnable,
    output logic regulatorOn,
    output logic regulatorLowPowerSel,
    output logic busVoltageIrq,
    output logic busVoltageResetReq
);
    logic regulatorOff_reg;
    logic busVoltageIrqPolarity_reg;
    logic regulatorLowPowerSel_reg;
    logic [3:0] reserved_reg;
    logic [7:0] sfrRdata_reg;
    logic busVoltagePresent;
    logic polarityMatch;
    logic regHit;
    logic writeHit;
    logic readHit;
    logic [7:0] regValue;
    logic [1:0] sinceReset_reg;
    logic [1:0] sinceReset_next;
    logic settled;

    // Bit 6 is status only, so readback compares every other bit
    localparam logic [7:0] WRITABLE_MASK = ~(8'h01 << rvc_pkg::PRESENT_BIT);

    // Pin is asynchronous to clk, so it is synchronised before use
    rvc_sync #(
        .STAGES(rvc_pkg::SYNC_STAGES)
    ) rvc_sync_inst (
        .clk(clk),
        .rst_n(rst_n),
        .din(busVoltagePin),
        .dout(busVoltagePresent)
    );

    assign regHit = (sfrAddr == rvc_pkg::REG_ADDR);
    assign writeHit = regHit && sfrWrite;
    assign readHit = regHit && sfrRead;
    assign sfrSelected = regHit;

    // Status bit is live, never stored
    assign regValue = {regulatorOff_reg, busVoltagePresent, busVoltageIrqPolarity_reg,
                       regulatorLowPowerSel_reg, reserved_reg};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regulatorOff_reg <= rvc_pkg::OFF_RESET;
            busVoltageIrqPolarity_reg <= rvc_pkg::POL_RESET;
            regulatorLowPowerSel_reg <= rvc_pkg::LOWPWR_RESET;
            reserved_reg <= rvc_pkg::RSVD_RESET;
        end else if (writeHit) begin
            regulatorOff_reg <= sfrWdata[rvc_pkg::OFF_BIT];
            busVoltageIrqPolarity_reg <= sfrWdata[rvc_pkg::POL_BIT];
            regulatorLowPowerSel_reg <= sfrWdata[rvc_pkg::LOWPWR_BIT];
            reserved_reg <= sfrWdata[3:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sfrRdata_reg <= 8'h00;
        end else if (readHit) begin
            sfrRdata_reg <= regValue;
        end
    end
    assign sfrRdata = sfrRdata_reg;

    assign regulatorOn = !regulatorOff_reg;
    assign regulatorLowPowerSel = regulatorLowPowerSel_reg;

    // Match is combinational so it follows the pin with no latch
    assign polarityMatch = busVoltageIrqPolarity_reg ? busVoltagePresent
                                                     : !busVoltagePresent;
    assign busVoltageIrq = busVoltageIrqEnable && polarityMatch;
    assign busVoltageResetReq = busResetSourceEnable && polarityMatch;

    // Edges since reset release, saturating; the live-status check waits out the sync chain
    assign sinceReset_next = (sinceReset_reg == 2'h3) ? sinceReset_reg : sinceReset_reg + 2'h1;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sinceReset_reg <= 2'h0;
        end else begin
            sinceReset_reg <= sinceReset_next;
        end
    end
    assign settled = (sinceReset_reg == 2'h3);

    // Compare written apart from the ternary above, so checks do not mirror it
    function automatic logic level_matches(input logic polarity, input logic level);
        return polarity == level;
    endfunction : level_matches

    sequence seq_write_then_read;
        writeHit ##1 (readHit && !writeHit);
    endsequence

    sequence seq_irq_then_mismatch;
        busVoltageIrq ##1 !level_matches(busVoltageIrqPolarity_reg, busVoltagePresent);
    endsequence

    sequence seq_reset_req_then_mismatch;
        busVoltageResetReq ##1 !level_matches(busVoltageIrqPolarity_reg, busVoltagePresent);
    endsequence

    AST_STATUS_READ: assert property (@(posedge clk) disable iff (!rst_n)
        readHit |=> sfrRdata[rvc_pkg::PRESENT_BIT] == $past(busVoltagePresent))
        else $error("Status bit read mismatch");

    AST_POL_LOW: assert property (@(posedge clk) disable iff (!rst_n)
        (busVoltageIrqEnable && !busVoltageIrqPolarity_reg && !busVoltagePresent)
        |-> busVoltageIrq)
        else $error("Low polarity interrupt missing");

    AST_POL_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
        (busVoltageIrqPolarity_reg && busVoltagePresent && busVoltageIrqEnable)
        |-> busVoltageIrq)
        else $error("High polarity interrupt missing");

    AST_LOWPWR_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
        writeHit |=> regulatorLowPowerSel == $past(sfrWdata[rvc_pkg::LOWPWR_BIT]))
        else $error("Low-power select not written");

    AST_LEVEL_NO_PENDING: assert property (@(posedge clk) disable iff (!rst_n)
        busVoltageIrq |-> polarityMatch)
        else $error("Interrupt held without match");

    AST_RESET_REQ: assert property (@(posedge clk) disable iff (!rst_n)
        busResetSourceEnable |-> busVoltageResetReq == polarityMatch)
        else $error("Reset request wrong");

    AST_OFF_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
        writeHit |=> regulatorOn == !$past(sfrWdata[rvc_pkg::OFF_BIT]))
        else $error("Regulator disable not written");

    AST_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        !writeHit |=> $stable(regulatorOn) && $stable(reserved_reg))
        else $error("Register changed without write");

    AST_HOLD_MODE: assert property (@(posedge clk) disable iff (!rst_n)
        !writeHit |=> $stable(regulatorLowPowerSel) && $stable(busVoltageIrqPolarity_reg))
        else $error("Mode or polarity changed without write");

    AST_POL_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
        writeHit |=> busVoltageIrqPolarity_reg == $past(sfrWdata[rvc_pkg::POL_BIT]))
        else $error("Polarity select not written");

    AST_STATUS_LIVE: assert property (@(posedge clk) disable iff (!rst_n)
        settled |-> busVoltagePresent == $past(busVoltagePin, rvc_pkg::SYNC_STAGES))
        else $error("Status does not follow the pin");

    AST_STATUS_STANDS: assert property (@(posedge clk) disable iff (!rst_n)
        !readHit |=> $stable(sfrRdata))
        else $error("Read data changed without a read");

    AST_READ_REFUSED: assert property (@(posedge clk) disable iff (!rst_n)
        (sfrRead && !regHit) |=> $stable(sfrRdata))
        else $error("Read of another address changed read data");

    AST_WRITE_REFUSED: assert property (@(posedge clk) disable iff (!rst_n)
        (sfrWrite && !regHit) |=> $stable(regulatorOn) && $stable(regulatorLowPowerSel)
            && $stable(busVoltageIrqPolarity_reg) && $stable(reserved_reg))
        else $error("Write to another address changed the register");

    AST_READBACK: assert property (@(posedge clk) disable iff (!rst_n)
        seq_write_then_read |=> (sfrRdata & WRITABLE_MASK)
            == ($past(sfrWdata, 2) & WRITABLE_MASK))
        else $error("Written fields not read back");

    AST_IRQ_EXACT: assert property (@(posedge clk) disable iff (!rst_n)
        busVoltageIrq == (busVoltageIrqEnable
            && level_matches(busVoltageIrqPolarity_reg, busVoltagePresent)))
        else $error("Interrupt level does not track the match");

    AST_RESET_REQ_EXACT: assert property (@(posedge clk) disable iff (!rst_n)
        busVoltageResetReq == (busResetSourceEnable
            && level_matches(busVoltageIrqPolarity_reg, busVoltagePresent)))
        else $error("Reset request does not track the match");

    AST_IRQ_DROPS: assert property (@(posedge clk) disable iff (!rst_n)
        seq_irq_then_mismatch |-> !busVoltageIrq)
        else $error("Interrupt held after the match ended");

    AST_RESET_REQ_DROPS: assert property (@(posedge clk) disable iff (!rst_n)
        seq_reset_req_then_mismatch |-> !busVoltageResetReq)
        else $error("Reset request held after the match ended");

    AST_IRQ_GATED: assert property (@(posedge clk) disable iff (!rst_n)
        !busVoltageIrqEnable |-> !busVoltageIrq)
        else $error("Interrupt raised while not enabled");

    AST_RESET_REQ_GATED: assert property (@(posedge clk) disable iff (!rst_n)
        !busResetSourceEnable |-> !busVoltageResetReq)
        else $error("Reset request raised while not selected");

    AST_RESET_VALUES: assert property (@(posedge clk) disable iff (!rst_n)
        (sinceReset_reg == 2'h0) |-> regulatorOn == !rvc_pkg::OFF_RESET
            && regulatorLowPowerSel == rvc_pkg::LOWPWR_RESET
            && busVoltageIrqPolarity_reg == rvc_pkg::POL_RESET
            && reserved_reg == rvc_pkg::RSVD_RESET)
        else $error("Register not at reset value after release");

    // One check per reserved bit, so a stuck bit shows up by itself
    for (genvar i = 0; i < $bits(reserved_reg); i++) begin : g_rsvd_chk
        AST_RSVD_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
            writeHit |=> reserved_reg[i] == $past(sfrWdata[i]))
            else $error("Reserved bit not kept as written");
    end
endmodule : rvc_regulator_control

//--- rvc_regulator_control_bench.sv
// Self-checking testbench for the regulator control register
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module rvc_regulator_control_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] sfrAddr = 8'h00;
    logic [7:0] sfrWdata = 8'h00;
    logic [7:0] sfrRdata;
    logic sfrWrite = 1'b0;
    logic sfrRead = 1'b0;
    logic pin = 1'b0;
    logic irqEn = 1'b0;
    logic rstEn = 1'b0;
    logic sfrSelected, regOn, lowPwr, irq, rstReq;
    int n_fail = 0;
    int n_checks = 0;
    initial begin
        forever #5 clk = ~clk;
    end
    rvc_regulator_control rvc_regulator_control_inst (.clk(clk), .rst_n(rst_n),
        .sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWdata(sfrWdata),
        .sfrRdata(sfrRdata), .sfrSelected(sfrSelected), .busVoltagePin(pin),
        .busVoltageIrqEnable(irqEn), .busResetSourceEnable(rstEn), .regulatorOn(regOn),
        .regulatorLowPowerSel(lowPwr), .busVoltageIrq(irq), .busVoltageResetReq(rstReq));
    // One-cycle strobes, launched and dropped at falling edges
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfrAddr = a;
        sfrWdata = d;
        sfrWrite = 1'b1;
        @(negedge clk);
        sfrWrite = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        sfrAddr = a;
        sfrRead = 1'b1;
        @(negedge clk);
        sfrRead = 1'b0;
        `CHK(sfrRdata, exp)
    endtask : rd
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        `CHK({regOn, lowPwr}, 2'b10)
        rd(8'hc9, 8'h00);
        `CHK(sfrSelected, 1'b1)
        pin = 1'b1;
        repeat (3) @(negedge clk);
        wr(8'hc9, 8'h1a);
        `CHK({regOn, lowPwr}, 2'b11)
        rd(8'hc9, 8'h5a);
        pin = 1'b0;
        repeat (3) @(negedge clk);
        // Bit 6 written as one must not stick
        wr(8'hc9, 8'hc5);
        @(negedge clk);
        wr(8'hc8, 8'h10);
        `CHK(sfrSelected, 1'b0)
        `CHK({regOn, lowPwr}, 2'b00)
        rd(8'hc9, 8'h85);
        @(negedge clk);
        rd(8'hc8, 8'h85);
        irqEn = 1'b1;
        rstEn = 1'b1;
        for (int k = 0; k < 4; k++) begin
            pin = k[0];
            wr(8'hc9, {2'b00, k[1], 5'h00});
            // Pin passes a two-flop synchroniser
            repeat (3) @(negedge clk);
            `CHK({irq, rstReq}, {2{k[0] == k[1]}})
            rd(8'hc9, {1'b0, k[0], k[1], 5'h00});
        end
        irqEn = 1'b0;
        rstEn = 1'b0;
        @(negedge clk);
        `CHK({irq, rstReq}, 2'b00)
        rstEn = 1'b1;
        @(negedge clk);
        `CHK({irq, rstReq}, 2'b01)
        rstEn = 1'b0;
        irqEn = 1'b1;
        @(negedge clk);
        `CHK({irq, rstReq}, 2'b10)
        irqEn = 1'b0;
        // Reset in mid-run must restore every stored field
        wr(8'hc9, 8'h9f);
        `CHK({regOn, lowPwr}, 2'b01)
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        `CHK({regOn, lowPwr, sfrRdata}, 10'h200)
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        rd(8'hc9, 8'h40);
        final_report;
    end
endmodule : rvc_regulator_control_bench

//--- rvc_sync.sv
// Two-flop synchroniser for a single asynchronous level
`timescale 1ns/1ps
module rvc_sync #(
    parameter int STAGES = rvc_pkg::SYNC_STAGES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic din,
    output logic dout
);
    logic [STAGES-1:0] chain_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chain_reg <= '0;
        end else begin
            chain_reg <= {chain_reg[STAGES-2:0], din};
        end
    end
    assign dout = chain_reg[STAGES-1];
endmodule : rvc_sync
